// File: design/see_params.svh
// Constants for the two-wire serial memory slave
`ifndef SEE_PARAMS_SVH
`define SEE_PARAMS_SVH

// Device address word layout
`define SEE_TYPE_CODE 4'hA
`define SEE_TYPE_MSB 7
`define SEE_TYPE_LSB 4
`define SEE_STRAP_MSB 3
`define SEE_STRAP_LSB 1
`define SEE_RW_BIT 0

// Array and page geometry
`define SEE_ADDR_W 13
`define SEE_MEM_BYTES 8192
`define SEE_MASK_LARGE 13'h1FFF
`define SEE_MASK_SMALL 13'h0FFF
`define SEE_PAGE_BYTES 32
`define SEE_PAGE_W 5
`define SEE_HI_W 5
`define SEE_BITS_PER_WORD 4'h8

// Pin vector layout after synchronisation
`define SEE_PIN_W 6
`define SEE_PIN_SCL 0
`define SEE_PIN_SDA 1
`define SEE_PIN_STRAP_LSB 2
`define SEE_PIN_STRAP_MSB 4
`define SEE_PIN_WP 5
`define SEE_PIN_RST_VAL 6'h03

// Timing
`define SEE_PROG_TIME_NS 5000000
`define SEE_CLK_PERIOD_NS 25
`define SEE_PROG_CNT_W 18

`endif

// File: design/see_pkg.sv
// Types shared by the two-wire serial memory slave
package see_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_WDATA,
		ST_RDATA,
		ST_PROG
	} see_state_t;

	typedef logic [7:0] see_byte_t;

endpackage

// File: design/see_pin_sync.sv
// Two-stage synchroniser for the asynchronous pin inputs
`timescale 1ns/1ps

module see_pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_q <= RST_VAL;
			o_q <= RST_VAL;
		end else begin
			meta_q <= i_d;
			o_q <= meta_q;
		end
	end

endmodule // see_pin_sync

// File: design/see_top.sv
// Two-wire serial memory slave: protocol engine, page buffer and array
`timescale 1ns/1ps
`include "see_params.svh"

// Functional notes
// R1: Write-protect high blocks every array change; low allows normal writes.
// R2: Smaller variant: 128 pages of 32 bytes, 12-bit word address.
// R3: Larger variant: 256 pages of 32 bytes, 13-bit word address.
// R4: SDA changes only while SCL low; changes with SCL high mark start/stop.
// R5: SDA falling with SCL high is a start, recognised at any time; the code ignores it during the programming cycle.
// R6: SDA rising with SCL high is a stop; after reads, go to standby.
// R7: Words are 8 bits; device acknowledges each received word on ninth clock.
// R8: Standby after power-up and after stop once internal work finishes.
// R9: Master recovers by clocking SCL up to nine times, then a start.
// R10: Device address word opens every operation; top nibble is fixed type code.
// R11: Next three address bits must match the strap select inputs.
// R12: Last device address bit: one is read, zero is write.
// R13: Match gets acknowledge; mismatch releases SDA and waits for next start.
// R14: Byte write: two word-address bytes, one data byte, each acknowledged, stop.
// R15: After write stop, self-timed programming up to 5 ms ignores all inputs.
// R16: Page write accepts up to 31 more data bytes, each acknowledged.
// R17: Only the lower five address bits advance; wrap within the page.
// R18: More than 32 bytes wrap and overwrite earlier bytes of the sequence.
// R19: Polling during programming is not acknowledged until the cycle ends.
// R20: Sample SDA on SCL rising; shift out after SCL falling.
// R21: Partial page writes program only received bytes.
// R22: SDA is only pulled low or released, never driven high.
// R23: Address counter holds last address plus one; reads wrap over whole array.
// R24: Reads continue while master acknowledges; master nack ends the read.
// R25: Word-address bits above the fitted array size are ignored.
// R26: Under write protect, bytes are still acknowledged but nothing is programmed.
module see_top #(
	parameter bit LARGE_VARIANT = 1'b1,
	parameter logic [`SEE_PROG_CNT_W-1:0] PROG_CYCLES =
		`SEE_PROG_CNT_W'(`SEE_PROG_TIME_NS / `SEE_CLK_PERIOD_NS)
) (
	input wire logic I_CLK_SYS,
	input wire logic I_SYS_RST,
	input wire logic I_SCL,
	input wire logic I_SDA,
	output logic O_SDA,
	output logic O_SDA_OE,
	input wire logic I_WP,
	input wire logic [2:0] I_STRAP_SELECT_INPUTS,
	output logic O_STANDBY
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [`SEE_PIN_W-1:0] pin_s;
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic [2:0] strap_s;
	logic scl_q;
	logic sda_q;

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	see_pkg::see_state_t state_q;
	logic [3:0] cnt_q;
	logic ack_ph_q;
	logic oe_q;
	logic sda_o_q;
	logic standby_q;
	see_pkg::see_byte_t rx_q;
	see_pkg::see_byte_t tx_q;
	logic [`SEE_ADDR_W-1:0] addr_q;
	logic [`SEE_ADDR_W-1:0] addr_mask;
	logic [`SEE_PAGE_BYTES-1:0] valid_q;
	logic [`SEE_PROG_CNT_W-1:0] prog_cnt_q;

	see_pkg::see_byte_t page_buf [0:`SEE_PAGE_BYTES-1];
	see_pkg::see_byte_t mem [0:`SEE_MEM_BYTES-1];

	logic active;
	logic start_take;
	logic rx_bit;
	logic byte_done;
	logic ack_end;
	logic tx_shift;
	logic master_nack;
	logic dev_match;
	logic rd_load;
	logic take_prog;
	logic prog_done;
	logic commit_en;
	logic [`SEE_PAGE_W-1:0] commit_idx;
	see_pkg::see_byte_t rd_byte;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and bus condition detection

	see_pin_sync #(
		.W(`SEE_PIN_W),
		.RST_VAL(`SEE_PIN_RST_VAL)
	) u_pin_sync (
		.i_clk(I_CLK_SYS),
		.i_rst(I_SYS_RST),
		.i_d({I_WP, I_STRAP_SELECT_INPUTS, I_SDA, I_SCL}),
		.o_q(pin_s)
	);

	assign scl_s = pin_s[`SEE_PIN_SCL];
	assign sda_s = pin_s[`SEE_PIN_SDA];
	assign strap_s = pin_s[`SEE_PIN_STRAP_MSB:`SEE_PIN_STRAP_LSB];
	assign wp_s = pin_s[`SEE_PIN_WP];

	// Idle-high history so reset never fakes a start or stop
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_q; // R20
	assign scl_fall = ~scl_s & scl_q; // R20
	assign start_det = scl_s & scl_q & sda_q & ~sda_s; // R4 R5 R9
	assign stop_det = scl_s & scl_q & ~sda_q & sda_s; // R4 R6

	////////////////////////////////////////////////////////////////////////////
	// Transfer phase decode

	assign addr_mask = LARGE_VARIANT ? `SEE_MASK_LARGE : `SEE_MASK_SMALL; // R2 R3
	// A start during programming is ignored, so polling sees no acknowledge
	assign start_take = start_det && (state_q != see_pkg::ST_PROG); // R15 R19
	// Start and stop cycles suspend bit handling so no half word is taken
	assign active = (state_q != see_pkg::ST_IDLE) && (state_q != see_pkg::ST_PROG)
		&& !start_det && !stop_det;
	assign rx_bit = active && scl_rise && !ack_ph_q && (cnt_q < `SEE_BITS_PER_WORD);
	assign byte_done = active && scl_fall && !ack_ph_q && (cnt_q == `SEE_BITS_PER_WORD);
	assign ack_end = active && scl_fall && ack_ph_q;
	assign tx_shift = active && scl_fall && !ack_ph_q && (state_q == see_pkg::ST_RDATA)
		&& (cnt_q < `SEE_BITS_PER_WORD);
	assign master_nack = active && scl_rise && ack_ph_q
		&& (state_q == see_pkg::ST_RDATA) && sda_s; // R24
	assign dev_match = (rx_q[`SEE_TYPE_MSB:`SEE_TYPE_LSB] == `SEE_TYPE_CODE) // R10
		&& (rx_q[`SEE_STRAP_MSB:`SEE_STRAP_LSB] == strap_s); // R11
	assign rd_load = ack_end && (((state_q == see_pkg::ST_DEV) && rx_q[`SEE_RW_BIT])
		|| (state_q == see_pkg::ST_RDATA)); // R12 R24
	// Protected or empty sequences end without a busy period
	assign take_prog = stop_det && (state_q == see_pkg::ST_WDATA)
		&& (|valid_q) && !wp_s; // R1 R26
	assign prog_done = (state_q == see_pkg::ST_PROG) && (prog_cnt_q == PROG_CYCLES - 1'b1);
	// Array read is combinational so the first bit is ready at the ack fall
	assign rd_byte = mem[addr_q];

	////////////////////////////////////////////////////////////////////////////
	// Protocol state

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			state_q <= see_pkg::ST_IDLE; // R8
		end else if (state_q == see_pkg::ST_PROG) begin
			if (prog_done) begin
				state_q <= see_pkg::ST_IDLE; // R8 R15
			end
		end else if (start_take) begin
			state_q <= see_pkg::ST_DEV; // R5
		end else if (stop_det) begin
			state_q <= take_prog ? see_pkg::ST_PROG : see_pkg::ST_IDLE; // R6 R15
		end else if (byte_done && (state_q == see_pkg::ST_DEV) && !dev_match) begin
			state_q <= see_pkg::ST_IDLE; // R13
		end else if (master_nack) begin
			state_q <= see_pkg::ST_IDLE; // R24
		end else if (ack_end) begin
			case (state_q)
				see_pkg::ST_DEV: begin
					if (rx_q[`SEE_RW_BIT]) begin // R12
						state_q <= see_pkg::ST_RDATA;
					end else begin
						state_q <= see_pkg::ST_ADDR_HI;
					end
				end
				see_pkg::ST_ADDR_HI: begin
					state_q <= see_pkg::ST_ADDR_LO; // R14
				end
				see_pkg::ST_ADDR_LO: begin
					state_q <= see_pkg::ST_WDATA; // R14
				end
				default: begin
					state_q <= state_q; // R16
				end
			endcase
		end
	end

	// Bit count within a word
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST || start_take || ack_end) begin
			cnt_q <= 4'h0;
		end else if (rx_bit) begin
			cnt_q <= cnt_q + 4'h1; // R7
		end
	end

	// Ninth clock phase; the acknowledge or the master's answer lives here
	// It is dropped whenever the engine leaves an active transfer
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST || !active) begin
			ack_ph_q <= 1'b0;
		end else if (byte_done) begin
			ack_ph_q <= 1'b1; // R7
		end else if (ack_end) begin
			ack_ph_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shift registers

	// Incoming byte, most significant bit first
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			rx_q <= 8'h00;
		end else if (rx_bit && (state_q != see_pkg::ST_RDATA)) begin
			rx_q <= {rx_q[6:0], sda_s}; // R20
		end
	end

	// Outgoing byte, most significant bit first
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			tx_q <= 8'h00;
		end else if (rd_load) begin
			tx_q <= rd_byte; // R24
		end else if (tx_shift) begin
			tx_q <= {tx_q[6:0], 1'b0}; // R20
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// SDA pull-down

	// Enable only ever pulls the line low; the pull-up makes the high level
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST || !active) begin
			oe_q <= 1'b0; // R13 R15
		end else if (byte_done) begin
			if (state_q == see_pkg::ST_RDATA) begin
				oe_q <= 1'b0; // R24
			end else if (state_q == see_pkg::ST_DEV) begin
				oe_q <= dev_match; // R13
			end else begin
				oe_q <= 1'b1; // R7 R14 R16 R26
			end
		end else if (ack_end) begin
			oe_q <= rd_load ? ~rd_byte[7] : 1'b0; // R20
		end else if (tx_shift) begin
			oe_q <= ~tx_q[6]; // R20
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			sda_o_q <= 1'b0;
		end else begin
			sda_o_q <= 1'b0; // R22
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Word address counter

	// Address bits above the fitted array are masked off
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			addr_q <= 13'h0000;
		end else if (byte_done && (state_q == see_pkg::ST_ADDR_HI)) begin
			addr_q[`SEE_ADDR_W-1:8] <= rx_q[`SEE_HI_W-1:0]
				& addr_mask[`SEE_ADDR_W-1:8]; // R25
		end else if (byte_done && (state_q == see_pkg::ST_ADDR_LO)) begin
			addr_q[7:0] <= rx_q; // R14
		end else if (byte_done && (state_q == see_pkg::ST_WDATA)) begin
			addr_q[`SEE_PAGE_W-1:0] <= addr_q[`SEE_PAGE_W-1:0] + 5'h01; // R17 R23
		end else if (rd_load) begin
			addr_q <= (addr_q + 13'h0001) & addr_mask; // R23
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Page buffer

	// Bytes land here first; the array changes only in the busy period
	always_ff @(posedge I_CLK_SYS) begin
		if (byte_done && (state_q == see_pkg::ST_WDATA)) begin
			page_buf[addr_q[`SEE_PAGE_W-1:0]] <= rx_q; // R16 R18
		end
	end

	// Marks which page entries were loaded in this sequence
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST || start_take || (state_q == see_pkg::ST_IDLE)) begin
			valid_q <= 32'h00000000;
		end else if (byte_done && (state_q == see_pkg::ST_WDATA)) begin
			valid_q[addr_q[`SEE_PAGE_W-1:0]] <= 1'b1; // R21
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Self-timed programming cycle

	// Busy period lasts exactly the programming count in clocks
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST || (state_q != see_pkg::ST_PROG)) begin
			prog_cnt_q <= '0;
		end else begin
			prog_cnt_q <= prog_cnt_q + 1'b1; // R15
		end
	end

	// One page entry per cycle during the first page-length cycles
	assign commit_idx = prog_cnt_q[`SEE_PAGE_W-1:0];
	assign commit_en = (state_q == see_pkg::ST_PROG)
		&& (prog_cnt_q[`SEE_PROG_CNT_W-1:`SEE_PAGE_W] == '0)
		&& valid_q[commit_idx]; // R21

	always_ff @(posedge I_CLK_SYS) begin
		if (commit_en) begin
			mem[{addr_q[`SEE_ADDR_W-1:`SEE_PAGE_W], commit_idx}] <= page_buf[commit_idx]; // R1 R17
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Standby indication and outputs

	// Standby follows the idle state one clock later
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			standby_q <= 1'b1; // R8
		end else begin
			standby_q <= (state_q == see_pkg::ST_IDLE); // R6 R8
		end
	end

	assign O_SDA = sda_o_q;
	assign O_SDA_OE = oe_q;
	assign O_STANDBY = standby_q;

endmodule // see_top

// File: test/see_mst.sv
// Two-wire bus master model: drives the clock and pulls the data line
`timescale 1ns/1ps
module see_mst (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_pull
);
	initial begin
		o_scl = 1'b1;
		o_pull = 1'b0;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// One 200 ns bit; data moves only in the low phase
	task automatic bt(input logic b, output logic r);
		tk(1);
		o_pull <= ~b;
		tk(3);
		o_scl <= 1'b1;
		tk(2);
		r = i_sda;
		tk(2);
		o_scl <= 1'b0;
	endtask
	task automatic start();
		tk(1);
		o_pull <= 1'b0;
		tk(3);
		o_scl <= 1'b1;
		tk(4);
		o_pull <= 1'b1;
		tk(4);
		o_scl <= 1'b0;
	endtask
	task automatic stop();
		tk(1);
		o_pull <= 1'b1;
		tk(3);
		o_scl <= 1'b1;
		tk(4);
		o_pull <= 1'b0;
		tk(4);
	endtask
	// Frees a slave left holding the data line, then opens a new frame
	task automatic recover();
		logic r;
		for (int i = 0; i < 9; i++) bt(1'b1, r);
		start();
	endtask
	task automatic wb(input logic [7:0] w, output logic nk);
		logic r;
		for (int i = 7; i >= 0; i--) bt(w[i], r);
		bt(1'b1, nk);
	endtask
	// Acknowledge keeps a read going, the last byte gets none
	task automatic rb(input logic last, output logic [7:0] w);
		logic r;
		for (int i = 7; i >= 0; i--) bt(1'b1, w[i]);
		bt(last, r);
	endtask
endmodule // see_mst

// File: test/see_chk.sv
// Bus-level assertions for the two-wire memory slave
`timescale 1ns/1ps
`include "see_params.svh"
module see_chk #(
	parameter bit LARGE_VARIANT = 1'b1,
	parameter logic [`SEE_PROG_CNT_W-1:0] PROG_CYCLES = 18'h100
) (
	input wire logic I_CLK_SYS,
	input wire logic I_SYS_RST,
	input wire logic I_SCL,
	input wire logic I_SDA,
	input wire logic O_SDA,
	input wire logic O_SDA_OE,
	input wire logic I_WP,
	input wire logic [2:0] I_STRAP_SELECT_INPUTS,
	input wire logic O_STANDBY
);
	logic scl_q, sda_q, in_dev_q, sel_q, rd_q, prog_q;
	logic [3:0] cnt_q;
	logic [7:0] word_q;
	logic [5:0] stop_q;
	logic [`SEE_PROG_CNT_W-1:0] pc_q;
	wire logic fall = scl_q & ~I_SCL;
	wire logic rise = ~scl_q & I_SCL;
	wire logic start = scl_q & I_SCL & sda_q & ~I_SDA;
	wire logic stop = scl_q & I_SCL & ~sda_q & I_SDA;
	wire logic hit = word_q[7:1] == {4'hA, I_STRAP_SELECT_INPUTS};
	always_ff @(posedge I_CLK_SYS) begin
		scl_q <= I_SCL;
		sda_q <= I_SDA;
		stop_q <= {stop_q[4:0], stop};
	end
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST || start) cnt_q <= 4'h0;
		else if (rise) cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
		if (rise) word_q <= {word_q[6:0], I_SDA};
	end
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) in_dev_q <= 1'b0;
		else if (start) in_dev_q <= 1'b1;
		else if (rise && cnt_q == 4'h9) in_dev_q <= 1'b0;
	end
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST || start) sel_q <= 1'b0;
		else if (fall && cnt_q == 4'h8 && in_dev_q) sel_q <= hit & ~prog_q;
		if (fall && cnt_q == 4'h8 && in_dev_q) rd_q <= word_q[0];
	end
	// Busy window opens once standby stays low well after a stop
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST || O_STANDBY) prog_q <= 1'b0;
		else if (stop_q[5]) prog_q <= 1'b1;
		pc_q <= prog_q ? pc_q + 1'b1 : '0;
	end
	////////////////////////////////////////
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_SYS_RST);
	sequence dev_end;
		fall && cnt_q == 4'h8 && in_dev_q && !prog_q;
	endsequence
	sequence data_end;
		fall && cnt_q == 4'h8 && !in_dev_q && sel_q && !rd_q;
	endsequence
	drive_low_a: assert property (O_SDA_OE |-> !O_SDA)
		else $error("data line driven high");
	reset_idle_a: assert property ($fell(I_SYS_RST) |-> !O_SDA_OE && O_STANDBY)
		else $error("not idle after reset");
	oe_low_a: assert property ($changed(O_SDA_OE) |-> !$past(I_SCL) && !$past(I_SCL, 2))
		else $error("data changed outside clock low");
	dev_ack_a: assert property (dev_end |-> ##4 (O_SDA_OE == hit))
		else $error("wrong answer to device word");
	data_ack_a: assert property (data_end |-> ##4 O_SDA_OE)
		else $error("write byte not acknowledged");
	unsel_quiet_a: assert property (!sel_q && !in_dev_q |-> !O_SDA_OE)
		else $error("unselected device drives");
	prog_quiet_a: assert property (prog_q |-> !O_SDA_OE)
		else $error("answer while programming");
	prog_len_a: assert property (pc_q <= PROG_CYCLES)
		else $error("programming too long");
	wp_idle_a: assert property (stop && I_WP && !prog_q |-> ##[1:8] O_STANDBY)
		else $error("protected write started programming");
	start_wake_a: assert property (start && !prog_q |-> ##[2:6] !O_STANDBY)
		else $error("start not recognised");
endmodule // see_chk
bind see_top see_chk #(.LARGE_VARIANT(LARGE_VARIANT), .PROG_CYCLES(PROG_CYCLES)) i_chk (
	.I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_SCL(I_SCL), .I_SDA(I_SDA),
	.O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE), .I_WP(I_WP),
	.I_STRAP_SELECT_INPUTS(I_STRAP_SELECT_INPUTS), .O_STANDBY(O_STANDBY));

// File: test/serial_eeprom_two_wire_slave_tb.sv
// Self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
module serial_eeprom_two_wire_slave_tb;
	localparam logic [2:0] strap = 3'h5;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wp = 1'b0;
	logic scl, pull, oe, osda, stby, nk;
	logic [7:0] d;
	logic [7:0] exp_q[$];
	int fail_count = 0;
	int cmp_count = 0;
	wire logic sda = ~(pull | (oe & ~osda));
	always #12.5 clk = ~clk;
	see_mst i_mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_pull(pull));
	see_top #(.PROG_CYCLES(18'h100)) i_dut (.I_CLK_SYS(clk), .I_SYS_RST(rst),
		.I_SCL(scl), .I_SDA(sda), .O_SDA(osda), .O_SDA_OE(oe), .I_WP(wp),
		.I_STRAP_SELECT_INPUTS(strap), .O_STANDBY(stby));
	////////////////////////////////////////
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic ack(input logic [7:0] w);
		i_mst.wb(w, nk);
		check({7'h00, nk}, 8'h00);
	endtask
	task automatic open(input logic [7:0] hi, input logic [7:0] lo);
		i_mst.start();
		ack({4'hA, strap, 1'b0});
		ack(hi);
		ack(lo);
	endtask
	task automatic rd(input logic [7:0] hi, input logic [7:0] lo);
		open(hi, lo);
		i_mst.start();
		ack({4'hA, strap, 1'b1});
		foreach (exp_q[i]) begin
			i_mst.rb(i == exp_q.size() - 1, d);
			check(d, exp_q[i]);
		end
		i_mst.stop();
	endtask
	// Standby rises only when programming ends, so wait a few clocks and then poll for it
	task automatic idle();
		i_mst.tk(8);
		for (int i = 0; i < 600 && stby !== 1'b1; i++) @(posedge clk);
		check({7'h00, stby}, 8'h01);
	endtask
	task automatic t_strap();
		for (int s = 0; s < 8; s++) begin
			i_mst.start();
			i_mst.wb({4'hA, 3'(s), 1'b0}, nk);
			i_mst.stop();
			check({7'h00, nk}, {7'h00, 3'(s) != strap});
		end
		i_mst.start();
		i_mst.wb({4'hB, strap, 1'b0}, nk);
		i_mst.stop();
		check({7'h00, nk}, 8'h01);
		$display("strap test done");
	endtask
	task automatic t_page();
		open(8'h01, 8'h3E);
		for (int i = 0; i < 34; i++) ack(8'h10 + 8'(i));
		i_mst.stop();
		i_mst.tk(8);
		check({7'h00, stby}, 8'h00);
		i_mst.start();
		i_mst.wb({4'hA, strap, 1'b0}, nk);
		check({7'h00, nk}, 8'h01);
		i_mst.stop();
		idle();
		i_mst.start();
		ack({4'hA, strap, 1'b0});
		i_mst.stop();
		for (int o = 0; o < 31; o++) exp_q.push_back(o > 29 ? 8'h30 : 8'h12 + 8'(o));
		rd(8'h01, 8'h20);
		i_mst.start();
		ack({4'hA, strap, 1'b1});
		i_mst.rb(1'b1, d);
		check(d, 8'h31);
		i_mst.stop();
		$display("page test done");
	endtask
	task automatic t_wp();
		wp <= 1'b1;
		open(8'h01, 8'h20);
		ack(8'h5A);
		i_mst.stop();
		i_mst.tk(8);
		check({7'h00, stby}, 8'h01);
		wp <= 1'b0;
		exp_q = {8'h12};
		rd(8'h01, 8'h20);
		$display("protect test done");
	endtask
	task automatic t_byte();
		open(8'hE1, 8'h21);
		ack(8'h77);
		i_mst.stop();
		idle();
		exp_q = {8'h12, 8'h77, 8'h14};
		rd(8'h01, 8'h20);
		$display("byte test done");
	endtask
	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		i_mst.tk(3);
		i_mst.recover();
		t_strap();
		t_page();
		t_wp();
		t_byte();
		stop_test();
	end
	// Tests need about 8000 cycles
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		stop_test();
	end
endmodule // serial_eeprom_two_wire_slave_tb
